// *** hdl/hrc_pkg.sv ***
// Constants and shared types for the host RAM access control block
`default_nettype none
package hrc_pkg;
	localparam int HRC_DW = 32;
	localparam int HRC_AW = 8;
	localparam int HRC_IW = 6;
	localparam int HRC_FIFO_DEPTH = 4;
	// Register select field values, one per host-visible register
	localparam logic [5:0] HRC_IDX_CTRL = 6'h04;
	localparam logic [5:0] HRC_IDX_ADDR = 6'h07;
	localparam logic [5:0] HRC_IDX_DATA = 6'h08;
	// Control register field positions
	localparam int HRC_LOCK_BIT = 7;
	localparam int HRC_WT_BIT = 5;
	localparam int HRC_RD_BIT = 3;
	localparam int HRC_DIR_BIT = 0;
	// Word address field of the host address register
	localparam int HRC_ADDR_LSB = 2;
	localparam int HRC_ADDR_MSB = 9;
	localparam logic [HRC_AW-1:0] HRC_ADDR_STEP = 8'h01;
	localparam logic [31:0] HRC_CTRL_RST = 32'h00000000;
	localparam logic [31:0] HRC_DATA_RST = 32'h00000000;

	typedef enum logic [1:0] {
		HRC_IDLE = 2'b01,
		HRC_RD_WAIT = 2'b10
	} hrc_state_t;

	typedef struct packed {
		hrc_state_t state;
		logic [2:0] wr_sync;
		logic [2:0] rd_sync;
		logic [1:0] rs_sync;
		logic [1:0][HRC_DW-1:0] wd_sync;
		logic [HRC_IW-1:0] index;
		logic lock;
		logic wt;
		logic rd;
		logic dir;
		logic [HRC_AW-1:0] addr;
		logic [HRC_DW-1:0] data;
		logic push_pend;
		logic fetch_pend;
		logic [HRC_DW-1:0] host_rdata;
		logic host_wait;
		logic [HRC_DW-1:0] cpu_rdata;
		logic ram_req;
		logic ram_we;
		logic [HRC_AW-1:0] ram_addr;
		logic [HRC_DW-1:0] ram_wdata;
	} hrc_regs_t;

	localparam hrc_regs_t HRC_REGS_RST = '{state: HRC_IDLE, default: '0};
endpackage
`default_nettype wire

// *** hdl/hrc_fifo_if.sv ***
// Valid/ready carrier between the control logic and the write FIFO
`default_nettype none
interface hrc_fifo_if #(parameter int W = 32) ();
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** hdl/hrc_fifo.sv ***
// Small flip-flop FIFO holding words bound for the shared RAM
`default_nettype none
module hrc_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input wire logic ref_clk,
	input wire logic srst,
	hrc_fifo_if.fifo fq
);
	localparam int PW = $clog2(D);
	localparam int CW = PW + 1;

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} hrc_fifo_st_t;

	hrc_fifo_st_t f_reg;
	hrc_fifo_st_t f_next;
	logic push;
	logic pop;

	assign fq.in_ready = (f_reg.cnt != CW'(D));
	assign fq.out_valid = (f_reg.cnt != '0);
	assign fq.out_data = f_reg.mem[f_reg.rp];
	assign push = fq.in_valid & fq.in_ready;
	assign pop = fq.out_valid & fq.out_ready;

	always_comb begin
		f_next = f_reg;
		for (int i = 0; i < D; i++) begin
			if (push && f_reg.wp == PW'(i)) begin
				f_next.mem[i] = fq.in_data;
			end
		end
		if (push) begin
			f_next.wp = (f_reg.wp == PW'(D - 1)) ? '0 : PW'(f_reg.wp + 1'b1);
		end
		if (pop) begin
			f_next.rp = (f_reg.rp == PW'(D - 1)) ? '0 : PW'(f_reg.rp + 1'b1);
		end
		if (push && !pop) begin
			f_next.cnt = CW'(f_reg.cnt + 1'b1);
		end else if (pop && !push) begin
			f_next.cnt = CW'(f_reg.cnt - 1'b1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end
endmodule
`default_nettype wire

// *** hdl/hrc_top.sv ***
// Host access control for the shared RAM: control, address, data paths
// Functional notes
// - 32-bit control register, all bits reset zero
// - Only host writes control; CPU reads only
// - Reserved control bits read zero, write zero
// - Lock holds triggers written alongside it
// - Read trigger plus lock: consecutive read
// - Write trigger plus lock: consecutive write
// - Write trigger stores data word at address
// - Unlocked write: one store, trigger self-clears
// - Read trigger loads addressed word into data
// - Unlocked read: one fetch, trigger self-clears
// - Mode lasts until trigger or lock cleared
// - Direction bit acts only while locked
// - Locked access steps address by plus/minus four
// - Bank changes leave control settings untouched
// - Address register holds word address, bits 9:2
`default_nettype none
module hrc_top
	import hrc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic host_rs,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [HRC_DW-1:0] host_wdata,
	output logic [HRC_DW-1:0] host_rdata,
	output logic host_wait,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [HRC_IW-1:0] cpu_index,
	input wire logic [HRC_DW-1:0] cpu_wdata,
	output logic [HRC_DW-1:0] cpu_rdata,
	input wire logic ram_ready,
	input wire logic [HRC_DW-1:0] ram_rdata,
	output logic ram_req,
	output logic ram_we,
	output logic [HRC_AW-1:0] ram_addr,
	output logic [HRC_DW-1:0] ram_wdata
);
	hrc_regs_t r_reg;
	hrc_regs_t r_next;
	logic wr_edge;
	logic rd_edge;
	logic drain_go;
	logic [HRC_DW-1:0] wd;

	hrc_fifo_if #(.W(HRC_DW)) fq ();

	hrc_fifo #(.W(HRC_DW), .D(HRC_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.fq(fq)
	);

	// Readback view; reserved positions are hard zero
	function automatic logic [HRC_DW-1:0] read_view(
		input logic [HRC_IW-1:0] idx,
		input hrc_regs_t s
	);
		logic [HRC_DW-1:0] v;
		v = '0;
		if (idx == HRC_IDX_CTRL) begin
			v[HRC_LOCK_BIT] = s.lock;
			v[HRC_WT_BIT] = s.wt;
			v[HRC_RD_BIT] = s.rd;
			v[HRC_DIR_BIT] = s.dir;
		end else if (idx == HRC_IDX_ADDR) begin
			v[HRC_ADDR_MSB:HRC_ADDR_LSB] = s.addr;
		end else if (idx == HRC_IDX_DATA) begin
			v = s.data;
		end
		return v;
	endfunction

	function automatic logic [HRC_AW-1:0] step_addr(
		input logic [HRC_AW-1:0] a,
		input logic down
	);
		return down ? HRC_AW'(a - HRC_ADDR_STEP)
			: HRC_AW'(a + HRC_ADDR_STEP);
	endfunction

	// Edges come from the second and third stages, never the first
	assign wr_edge = r_reg.wr_sync[1] & ~r_reg.wr_sync[2];
	assign rd_edge = r_reg.rd_sync[1] & ~r_reg.rd_sync[2];
	assign wd = r_reg.wd_sync[1];

	// Stores drain ahead of fetches so a read never overtakes a write
	assign drain_go = (r_reg.state == HRC_IDLE) && ram_ready;
	assign fq.in_valid = r_reg.push_pend;
	assign fq.in_data = r_reg.data;
	assign fq.out_ready = drain_go;

	always_comb begin
		r_next = r_reg;
		r_next.wr_sync = {r_reg.wr_sync[1:0], host_wr};
		r_next.rd_sync = {r_reg.rd_sync[1:0], host_rd};
		r_next.rs_sync = {r_reg.rs_sync[0], host_rs};
		r_next.wd_sync = {r_reg.wd_sync[0], host_wdata};
		r_next.ram_req = 1'b0;
		r_next.ram_we = 1'b0;

		if (r_reg.push_pend && fq.in_ready) begin
			r_next.push_pend = 1'b0;
			if (!r_reg.lock) begin
				r_next.wt = 1'b0;
			end
		end

		if (fq.out_valid && drain_go) begin
			r_next.ram_req = 1'b1;
			r_next.ram_we = 1'b1;
			r_next.ram_addr = r_reg.addr;
			r_next.ram_wdata = fq.out_data;
			if (r_reg.lock) begin
				r_next.addr = step_addr(r_reg.addr, r_reg.dir);
			end
		end else if (drain_go && r_reg.fetch_pend && !r_reg.push_pend) begin
			r_next.ram_req = 1'b1;
			r_next.ram_addr = r_reg.addr;
			r_next.fetch_pend = 1'b0;
			r_next.state = HRC_RD_WAIT;
		end

		case (r_reg.state)
			HRC_RD_WAIT: begin
				r_next.state = HRC_IDLE;
				r_next.data = ram_rdata;
				if (r_reg.lock) begin
					r_next.addr = step_addr(r_reg.addr, r_reg.dir);
				end else begin
					r_next.rd = 1'b0;
				end
			end
			default: begin
				r_next.state = r_next.state;
			end
		endcase

		// CPU sees control, address and data (not the index) but may only change the data word
		if (cpu_rd) begin
			r_next.cpu_rdata = read_view(cpu_index, r_reg);
		end
		if (cpu_wr && cpu_index == HRC_IDX_DATA) begin
			r_next.data = cpu_wdata;
		end

		if (wr_edge) begin
			if (r_reg.rs_sync[1]) begin
				r_next.index = wd[HRC_IW-1:0];
			end else if (r_reg.index == HRC_IDX_CTRL) begin
				// Bank selection has no path into these bits
				r_next.lock = wd[HRC_LOCK_BIT];
				r_next.wt = wd[HRC_WT_BIT];
				r_next.rd = wd[HRC_RD_BIT];
				r_next.dir = wd[HRC_DIR_BIT];
				r_next.fetch_pend = 1'b0;
				if (wd[HRC_WT_BIT]) begin
					r_next.push_pend = !wd[HRC_LOCK_BIT];
				end else if (wd[HRC_RD_BIT]) begin
					r_next.fetch_pend = 1'b1;
				end
			end else if (r_reg.index == HRC_IDX_ADDR) begin
				r_next.addr = wd[HRC_ADDR_MSB:HRC_ADDR_LSB];
			end else if (r_reg.index == HRC_IDX_DATA) begin
				r_next.data = wd;
				if (r_reg.lock && r_reg.wt) begin
					r_next.push_pend = 1'b1;
				end
			end
		end

		if (rd_edge) begin
			if (r_reg.rs_sync[1]) begin
				r_next.host_rdata = {{(HRC_DW-HRC_IW){1'b0}}, r_reg.index};
			end else begin
				r_next.host_rdata = read_view(r_reg.index, r_reg);
				if (r_reg.index == HRC_IDX_DATA && r_reg.lock && r_reg.rd) begin
					r_next.fetch_pend = 1'b1;
				end
			end
		end

		// Host must hold off while a store is still waiting for room
		r_next.host_wait = r_next.push_pend | ~fq.in_ready;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r_reg <= HRC_REGS_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign host_rdata = r_reg.host_rdata;
	assign host_wait = r_reg.host_wait;
	assign cpu_rdata = r_reg.cpu_rdata;
	assign ram_req = r_reg.ram_req;
	assign ram_we = r_reg.ram_we;
	assign ram_addr = r_reg.ram_addr;
	assign ram_wdata = r_reg.ram_wdata;

	logic host_ctrl_wr;
	logic host_addr_wr;
	assign host_ctrl_wr = wr_edge && !r_reg.rs_sync[1]
		&& r_reg.index == HRC_IDX_CTRL;
	assign host_addr_wr = wr_edge && !r_reg.rs_sync[1]
		&& r_reg.index == HRC_IDX_ADDR;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_ctrl_reserved: assert property (cpu_rd && cpu_index == HRC_IDX_CTRL
		|=> cpu_rdata[31:8] == '0 && cpu_rdata[6] == 1'b0
		&& cpu_rdata[4] == 1'b0 && cpu_rdata[2:1] == 2'b00)
		else $error("reserved control bits not zero");
	a_cpu_no_ctrl: assert property (!host_ctrl_wr |=> $stable(r_reg.lock)
		&& $stable(r_reg.dir))
		else $error("control changed without host write");
	a_single_wt_clear: assert property (r_reg.push_pend && fq.in_ready
		&& !r_reg.lock && !host_ctrl_wr |=> !r_reg.wt)
		else $error("single write trigger not cleared");
	a_single_rd_clear: assert property (r_reg.state == HRC_RD_WAIT
		&& !r_reg.lock && !host_ctrl_wr |=> !r_reg.rd)
		else $error("single read trigger not cleared");
	a_read_load: assert property (r_reg.state == HRC_RD_WAIT && !wr_edge
		&& !cpu_wr |=> r_reg.data == $past(ram_rdata))
		else $error("fetched word not loaded");
	a_store_issue: assert property (fq.out_valid && drain_go
		|=> ram_req && ram_we && ram_wdata == $past(fq.out_data)
		&& ram_addr == $past(r_reg.addr))
		else $error("store not issued with queued word");
	a_addr_inc: assert property (r_reg.state == HRC_RD_WAIT && r_reg.lock
		&& !r_reg.dir && !host_addr_wr
		|=> r_reg.addr == HRC_AW'($past(r_reg.addr) + 1'b1))
		else $error("address did not step up");
	a_addr_hold: assert property (!r_reg.lock && !host_addr_wr
		|=> $stable(r_reg.addr))
		else $error("address moved while unlocked");
	a_mode_hold: assert property (r_reg.lock && r_reg.rd && !host_ctrl_wr
		|=> r_reg.rd && r_reg.lock)
		else $error("consecutive read mode dropped");
	a_addr_low_zero: assert property (cpu_rd && cpu_index == HRC_IDX_ADDR
		|=> cpu_rdata[1:0] == 2'b00 && cpu_rdata[31:10] == '0)
		else $error("address readback malformed");

	c_single_write: cover property (r_reg.push_pend && !r_reg.lock
		##[1:20] ram_req && ram_we);
	c_burst_read: cover property (r_reg.lock && r_reg.rd
		&& r_reg.state == HRC_RD_WAIT ##[1:40] r_reg.state == HRC_RD_WAIT);
	c_fifo_full: cover property (!fq.in_ready);
endmodule
`default_nettype wire

// *** testbench/hrc_ram_model.sv ***
// Shared RAM stand-in answering the block's word requests
`default_nettype none
module hrc_ram_model
	import hrc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic stall,
	input wire logic ram_req,
	input wire logic ram_we,
	input wire logic [HRC_AW-1:0] ram_addr,
	input wire logic [HRC_DW-1:0] ram_wdata,
	output logic ram_ready,
	output logic [HRC_DW-1:0] ram_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [HRC_DW-1:0] mem [256];
	int n_st = 0;
	assign ram_ready = !stall;
	logic [HRC_DW-1:0] scr;
	initial scr = 32'h0;
	// Fetched word stands only while the fetch request does
	assign ram_rdata = (ram_req && !ram_we) ? mem[ram_addr] : scr;
	// Scrambled filler exposes a fetch sampled outside its cycle
	always @(posedge ref_clk) begin
		scr <= ~scr;
		if (ram_req && ram_we) begin
			mem[ram_addr] <= ram_wdata;
			n_st <= n_st + 1;
		end
	end
endmodule
`default_nettype wire

// *** testbench/test_host_ram_access_control.sv ***
// Self-checking bench for the host RAM access control block
`default_nettype none
module test_host_ram_access_control
	import hrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, srst = 1, host_rs = 1, host_wr = 0, host_rd = 0;
	logic cpu_rd = 0, cpu_wr = 0, stall = 0;
	logic [HRC_IW-1:0] cpu_index = '0;
	logic [HRC_DW-1:0] host_wdata = '0, cpu_wdata = '0;
	logic [HRC_DW-1:0] host_rdata, cpu_rdata, ram_rdata, ram_wdata, v;
	logic host_wait, ram_ready, ram_req, ram_we;
	logic [HRC_AW-1:0] ram_addr;
	int n_fail = 0, tests_run = 0, n;
	always #5 ref_clk = ~ref_clk;
	hrc_top uut (.ref_clk, .srst, .host_rs, .host_wr, .host_rd,
		.host_wdata, .host_rdata, .host_wait, .cpu_rd, .cpu_wr,
		.cpu_index, .cpu_wdata, .cpu_rdata, .ram_ready, .ram_rdata,
		.ram_req, .ram_we, .ram_addr, .ram_wdata);
	hrc_ram_model ram (.ref_clk, .stall, .ram_req, .ram_we, .ram_addr,
		.ram_wdata, .ram_ready, .ram_rdata);
	task automatic wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Data must be steady well before the strobe: pins pass two syncs
	task automatic hw(input logic rs, input logic [31:0] d);
		int i;
		i = 0;
		while (host_wait === 1'b1 && i < 200) begin
			@(negedge ref_clk);
			i++;
		end
		host_rs = rs;
		host_wdata = d;
		repeat (3) @(negedge ref_clk);
		host_wr = 1;
		repeat (4) @(negedge ref_clk);
		host_wr = 0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic hr(input logic rs, output logic [31:0] d);
		host_rs = rs;
		repeat (3) @(negedge ref_clk);
		host_rd = 1;
		repeat (5) @(negedge ref_clk);
		d = host_rdata;
		host_rd = 0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic wreg(input logic [5:0] i, input logic [31:0] d);
		hw(1, {26'h0, i});
		hw(0, d);
	endtask
	task automatic rreg(input logic [5:0] i, input logic [31:0] e);
		hw(1, {26'h0, i});
		hr(0, v);
		check(v, e);
	endtask
	task automatic cpu(input logic w, input logic [5:0] i,
		input logic [31:0] d);
		cpu_index = i;
		cpu_wdata = d;
		cpu_wr = w;
		cpu_rd = !w;
		@(negedge ref_clk);
		cpu_wr = 0;
		cpu_rd = 0;
		@(negedge ref_clk);
	endtask
	task automatic cchk(input logic [5:0] i, input logic [31:0] e);
		cpu(0, i, 32'h0);
		check(cpu_rdata, e);
	endtask
	initial begin
		#200000;
		n_fail++;
		wrap_up;
	end
	initial begin
		for (int k = 0; k < 256; k++)
			ram.mem[k] = {24'h5A0000, k[7:0]};
		repeat (2) @(negedge ref_clk);
		srst = 0;
		@(negedge ref_clk);
		cchk(HRC_IDX_CTRL, 32'h0);
		cchk(HRC_IDX_DATA, 32'h0);
		wreg(HRC_IDX_ADDR, 32'h40);
		wreg(HRC_IDX_DATA, 32'hA5A50001);
		wreg(HRC_IDX_CTRL, 32'h21);
		repeat (8) @(negedge ref_clk);
		rreg(HRC_IDX_CTRL, 32'h1);
		check(ram.mem[8'h10], 32'hA5A50001);
		check(ram.n_st, 32'h1);
		rreg(HRC_IDX_ADDR, 32'h40);
		wreg(HRC_IDX_ADDR, 32'h80);
		wreg(HRC_IDX_CTRL, 32'h08);
		repeat (8) @(negedge ref_clk);
		rreg(HRC_IDX_DATA, 32'h5A000020);
		cchk(HRC_IDX_CTRL, 32'h0);
		cchk(HRC_IDX_ADDR, 32'h80);
		for (int d = 0; d < 2; d++) begin
			wreg(HRC_IDX_ADDR, 32'h100);
			wreg(HRC_IDX_CTRL, {31'h50, d[0]});
			stall = d[0];
			hw(1, {26'h0, HRC_IDX_DATA});
			for (int k = 0; k < 3; k++)
				hw(0, {24'hC0DE00, d[3:0], k[3:0]});
			stall = 0;
			repeat (10) @(negedge ref_clk);
			rreg(HRC_IDX_CTRL, {31'h50, d[0]});
			for (int k = 0; k < 3; k++)
				check(ram.mem[d ? 8'h40 - k[7:0] : 8'h40 + k[7:0]],
					{24'hC0DE00, d[3:0], k[3:0]});
			rreg(HRC_IDX_ADDR, d ? 32'hF4 : 32'h10C);
			wreg(HRC_IDX_CTRL, 32'h0);
		end
		wreg(HRC_IDX_ADDR, 32'hC8);
		wreg(HRC_IDX_CTRL, 32'h89);
		repeat (8) @(negedge ref_clk);
		for (int k = 0; k < 3; k++)
			rreg(HRC_IDX_DATA, {24'h5A0000, 8'h32 - k[7:0]});
		rreg(HRC_IDX_ADDR, 32'hB8);
		wreg(HRC_IDX_CTRL, 32'h81);
		rreg(HRC_IDX_DATA, 32'h5A00002F);
		rreg(HRC_IDX_ADDR, 32'hB8);
		cpu(1, HRC_IDX_CTRL, 32'hA8);
		cpu(1, HRC_IDX_ADDR, 32'h3FC);
		cchk(HRC_IDX_CTRL, 32'h81);
		cchk(HRC_IDX_ADDR, 32'hB8);
		cpu(1, HRC_IDX_DATA, 32'h12345678);
		rreg(HRC_IDX_DATA, 32'h12345678);
		// RAM stalled: the FIFO must refuse once it holds its depth
		wreg(HRC_IDX_ADDR, 32'h300);
		wreg(HRC_IDX_CTRL, 32'hA0);
		hw(1, {26'h0, HRC_IDX_DATA});
		stall = 1;
		n = 0;
		while (host_wait !== 1'b1 && n < 8) begin
			hw(0, {24'hF1F0F0, n[7:0]});
			n++;
		end
		check(n, HRC_FIFO_DEPTH);
		stall = 0;
		repeat (12) @(negedge ref_clk);
		check(host_wait, 1'b0);
		check(ram.mem[8'hC3], 32'hF1F0F003);
		rreg(HRC_IDX_ADDR, 32'h310);
		wreg(HRC_IDX_CTRL, 32'h0);
		wrap_up;
	end
endmodule
`default_nettype wire
